// file: src/pwm_gen_pkg.sv
// Package: register map, field layout, reset values and timing counts
// of the three-generator motor PWM block.
// Assumes a 32-bit APB slave with word-aligned registers.
package pwm_gen_pkg;
   localparam int CNT_W = 15;
   localparam int VAL_W = 16;
   localparam int DT_W  = 12;
   localparam int NGEN  = 3;

   // Byte offsets (printed offsets that are multiples of four)
   localparam logic [7:0] OFS_DEADTIME_C = 8'h00;
   localparam logic [7:0] OFS_MODULUS_C  = 8'h34;
   // Own registers
   localparam logic [7:0] OFS_CONTROL    = 8'h04;
   localparam logic [7:0] OFS_MODULUS_A  = 8'h08;
   localparam logic [7:0] OFS_MODULUS_B  = 8'h0C;
   localparam logic [7:0] OFS_VALUE_A    = 8'h10;
   localparam logic [7:0] OFS_VALUE_B    = 8'h14;
   localparam logic [7:0] OFS_VALUE_C    = 8'h18;
   localparam logic [7:0] OFS_PRESCALE   = 8'h1C;
   localparam logic [7:0] OFS_COUNT_A    = 8'h20;
   localparam logic [7:0] OFS_COUNT_B    = 8'h24;
   localparam logic [7:0] OFS_COUNT_C    = 8'h28;
   localparam logic [7:0] OFS_DEADTIME_A = 8'h2C;
   localparam logic [7:0] OFS_DEADTIME_B = 8'h30;
   localparam logic [7:0] OFS_DT_BUS_C   = 8'h38;

   // Control register fields
   localparam int CTL_MTG_BIT   = 0;
   localparam int CTL_WP_BIT    = 1;
   localparam int CTL_LDOK_LSB  = 4;
   localparam int CTL_ALIGN_LSB = 8;

   // Prescale register: two bits per generator
   localparam int PRS_FIELD_W = 2;

   localparam logic [DT_W-1:0]  DEADTIME_RESET = 12'h0FFF;
   localparam logic [CNT_W-1:0] MODULUS_RESET  = 15'h0000;
   localparam logic [CNT_W-1:0] COUNT_MAX      = 15'h7FFF;
   localparam logic [CNT_W-1:0] COUNT_START    = 15'h0001;
endpackage : pwm_gen_pkg

// file: src/pwm_gen_core.sv
// One PWM generator: prescaler, 15-bit up/down counter, compare.
// Assumes buffered values are applied by the parent only on reload.
`timescale 1ns/1ps
module pwm_gen_core
   import pwm_gen_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [1:0]   prescale,
   input  wire logic [W-1:0] modulus,
   input  wire logic [15:0]  value,
   input  wire logic         center,
   output logic [W-1:0]      count_q,
   output logic              pwm_q,
   output logic              reload
);
   // The compare path works on the low 15 value bits, so wider counters cannot be served
   if (W < 2 || W > 15) begin : g_width_check
      $error("pwm_gen_core: counter width unsupported");
   end

   logic [2:0]   div_q;
   logic         tick;
   logic         down_q;
   logic [W-1:0] use_val;

   // Divide by 1, 2, 4 or 8 from the select code
   always_comb begin
      case (prescale) // [RULE8] [RULE9]
         2'b00:   tick = 1'b1;
         2'b01:   tick = div_q[0];
         2'b10:   tick = &div_q[1:0];
         default: tick = &div_q;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 3'd0;
      end else begin
         div_q <= div_q + 3'd1;
      end
   end

   // Negative values clamp to zero, large ones to the modulus [RULE15] [RULE16]
   assign use_val = value[15] ? '0 : (value[14:0] > 15'(modulus) ? modulus : value[W-1:0]);

   // Zero modulus: free count down from max
   assign reload = tick && (modulus == '0 ? count_q == '0 :
                            center ? (down_q && count_q == COUNT_START[W-1:0])
                                   : count_q == modulus);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= COUNT_START[W-1:0];
         down_q  <= 1'b0;
      end else if (tick) begin
         if (modulus == '0) begin
            count_q <= (count_q == '0) ? COUNT_MAX[W-1:0] : count_q - 1'b1; // [RULE13]
         end else if (!center) begin
            count_q <= (count_q >= modulus) ? COUNT_START[W-1:0] : count_q + 1'b1;
            down_q  <= 1'b0; // [RULE12] [RULE18]
         end else if (!down_q) begin
            // Top value held for two ticks so one period is twice the modulus
            if (count_q >= modulus) begin
               down_q  <= 1'b1; // [RULE11] [RULE18]
               count_q <= modulus;
            end else begin
               count_q <= count_q + 1'b1;
            end
         end else begin
            if (count_q <= COUNT_START[W-1:0]) begin
               down_q <= 1'b0;
            end else begin
               count_q <= count_q - 1'b1;
            end
         end
      end
   end

   // Edge: active for count <= value; center: active while count <= value both ways
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_q <= 1'b0;
      end else begin
         pwm_q <= (use_val != '0) && (count_q <= use_val); // [RULE14]
      end
   end
endmodule : pwm_gen_core

// file: src/motor_pwm_period_generator.sv
// Top of the three-generator PWM block with its APB register file.
// Assumes one 200 MHz bus clock and inputs synchronous to it.
//
// How it works
// RULE1: Modulus is period in PWM clocks; in center mode the period is twice the modulus
// RULE2: Modulus buffered, applied at reload with load-okay
// RULE3: Generator C registers writable only in multi-generator mode; the value C register is written in either mode
// RULE4: Deadtime count twelve bits, resets to 0x0FFF
// RULE5: Write-protect blocks further deadtime writes
// RULE6: Deadtime bus clocks equal divisor times count minus one; divide-by-1 gives the count itself
// RULE7: Pairs A,B,C; select picks three or one
// RULE8: Per-generator prescaler, applied at reload only
// RULE9: Select codes 00..11 divide by 1,2,4,8
// RULE10: Fifteen-bit counter, per-pair alignment select
// RULE11: Center mode counts up then down
// RULE12: Edge mode counts up only
// RULE13: Zero modulus counts down from 0x7FFF
// RULE14: Signed 16-bit pulse value in PWM clocks
// RULE15: Value clamps to always off or always on
// RULE16: Negative value treated as zero
// RULE17: Load-okay clears itself after reload transfer
// RULE18: Counter restarts or reverses at turning points
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module motor_pwm_period_generator
   import pwm_gen_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [5:0]       pwm_out
);
   ////////////////////////////////////////////////////////////////////////////
   logic                      mtg_q;
   logic                      wp_q;
   logic [NGEN-1:0]           ldok_q;
   logic [NGEN-1:0]           align_q;
   logic [NGEN-1:0][CNT_W-1:0] mod_buf_q, mod_act_q;
   logic [NGEN-1:0][VAL_W-1:0] val_buf_q, val_act_q;
   logic [NGEN-1:0][1:0]      prs_buf_q, prs_act_q;
   logic [NGEN-1:0][DT_W-1:0] dt_q;
   logic [NGEN-1:0][CNT_W-1:0] count;
   logic [NGEN-1:0]           pwm_raw;
   logic [NGEN-1:0]           reload;
   logic [NGEN-1:0]           reload_a;
   logic                      wr_en;
   logic                      rd_en;
   logic [31:0]               rdata_d;
   logic                      hit;
   logic [18:0]               dt_bus_c;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   // Single-generator mode runs B and C on A's timing
   assign reload_a = mtg_q ? reload : {NGEN{reload[0]}}; // [RULE7]

   ////////////////////////////////////////////////////////////////////////////
   // Control: mode, write protect, alignment, load-okay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mtg_q   <= 1'b0;
         wp_q    <= 1'b0;
         align_q <= '0;
      end else if (wr_en && paddr == OFS_CONTROL) begin
         mtg_q   <= pwdata[CTL_MTG_BIT];
         wp_q    <= wp_q | pwdata[CTL_WP_BIT];
         align_q <= pwdata[CTL_ALIGN_LSB +: NGEN];
      end
   end

   // Load-okay: a control write (bit 0 always, bits 1-2 in multi-generator mode) wins over the reload clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ldok_q <= '0;
      end else begin
         for (int g = 0; g < NGEN; g++) begin
            if (wr_en && paddr == OFS_CONTROL && (g == 0 || mtg_q)) begin
               ldok_q[g] <= pwdata[CTL_LDOK_LSB + g];
            end else if (reload_a[g] && ldok_q[g]) begin
               ldok_q[g] <= 1'b0; // [RULE17]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffered registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_buf_q <= {NGEN{MODULUS_RESET}};
         val_buf_q <= '0;
         prs_buf_q <= '0;
      end else if (wr_en) begin
         case (paddr)
            OFS_MODULUS_A: mod_buf_q[0] <= pwdata[CNT_W-1:0]; // [RULE1]
            OFS_MODULUS_B: if (mtg_q) mod_buf_q[1] <= pwdata[CNT_W-1:0];
            OFS_MODULUS_C: if (mtg_q) mod_buf_q[2] <= pwdata[CNT_W-1:0]; // [RULE3]
            OFS_VALUE_A:   val_buf_q[0] <= pwdata[VAL_W-1:0]; // [RULE14]
            OFS_VALUE_B:   val_buf_q[1] <= pwdata[VAL_W-1:0];
            OFS_VALUE_C:   val_buf_q[2] <= pwdata[VAL_W-1:0];
            OFS_PRESCALE: begin
               prs_buf_q[0] <= pwdata[1:0];
               if (mtg_q) begin
                  prs_buf_q[1] <= pwdata[3:2];
                  prs_buf_q[2] <= pwdata[5:4];
               end
            end
            default: ;
         endcase
      end
   end

   // Transfer to active set at reload with load-okay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_act_q <= {NGEN{MODULUS_RESET}};
         val_act_q <= '0;
         prs_act_q <= '0;
      end else begin
         for (int g = 0; g < NGEN; g++) begin
            if (reload_a[g] && ldok_q[mtg_q ? g : 0]) begin
               mod_act_q[g] <= mtg_q ? mod_buf_q[g] : mod_buf_q[0]; // [RULE2]
               prs_act_q[g] <= mtg_q ? prs_buf_q[g] : prs_buf_q[0]; // [RULE8]
               val_act_q[g] <= val_buf_q[g];
            end
         end
      end
   end

   // Deadtime counts, locked by write protect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dt_q <= {NGEN{DEADTIME_RESET}}; // [RULE4]
      end else if (wr_en && !wp_q) begin // [RULE5]
         case (paddr)
            OFS_DEADTIME_A: dt_q[0] <= pwdata[DT_W-1:0];
            OFS_DEADTIME_B: if (mtg_q) dt_q[1] <= pwdata[DT_W-1:0];
            OFS_DEADTIME_C: if (mtg_q) dt_q[2] <= pwdata[DT_W-1:0]; // [RULE3]
            default: ;
         endcase
      end
   end

   // Deadtime length in bus clocks for pair C, read-only
   always_comb begin
      case (prs_act_q[2]) // [RULE9]
         2'b00:   dt_bus_c = {7'd0, dt_q[2]}; // [RULE6]
         2'b01:   dt_bus_c = {6'd0, dt_q[2], 1'b0} - 19'd1;
         2'b10:   dt_bus_c = {5'd0, dt_q[2], 2'b00} - 19'd1;
         default: dt_bus_c = {4'd0, dt_q[2], 3'b000} - 19'd1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Generators
   for (genvar g = 0; g < NGEN; g++) begin : gen_pwm
      pwm_gen_core #(.W(CNT_W)) u_core (
         .pclk     (pclk),
         .presetn  (presetn),
         .prescale (prs_act_q[g]),                   // [RULE8]
         .modulus  (mod_act_q[g]),                   // [RULE13]
         .value    (val_act_q[g]),                   // [RULE15] [RULE16]
         .center   (!align_q[mtg_q ? g : 0]),        // [RULE10] [RULE11] [RULE12] [RULE18]
         .count_q  (count[g]),
         .pwm_q    (pwm_raw[g]),
         .reload   (reload[g])
      );
   end

   // Pair outputs: top follows the generator, bottom is its complement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out <= '0;
      end else begin
         for (int g = 0; g < NGEN; g++) begin
            pwm_out[2*g]   <= pwm_raw[g]; // [RULE7]
            pwm_out[2*g+1] <= !pwm_raw[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read path, registered in setup so access completes in one cycle
   always_comb begin
      rdata_d = 32'h0000_0000;
      hit     = 1'b1;
      case (paddr)
         OFS_CONTROL:    rdata_d = {21'd0, align_q, 1'b0, (ldok_q & {{2{mtg_q}}, 1'b1}),
                                    2'b00, wp_q, mtg_q};
         OFS_MODULUS_A:  rdata_d = {17'd0, mod_buf_q[0]};
         OFS_MODULUS_B:  rdata_d = {17'd0, mod_buf_q[1]};
         OFS_MODULUS_C:  rdata_d = {17'd0, mod_buf_q[2]}; // [RULE2] [RULE3]
         OFS_VALUE_A:    rdata_d = {16'd0, val_buf_q[0]};
         OFS_VALUE_B:    rdata_d = {16'd0, val_buf_q[1]};
         OFS_VALUE_C:    rdata_d = {16'd0, val_buf_q[2]};
         OFS_PRESCALE:   rdata_d = {26'd0, prs_buf_q[2], prs_buf_q[1], prs_buf_q[0]};
         OFS_COUNT_A:    rdata_d = {17'd0, count[0]};
         OFS_COUNT_B:    rdata_d = {17'd0, count[1]};
         OFS_COUNT_C:    rdata_d = {17'd0, count[2]};
         OFS_DEADTIME_A: rdata_d = {20'd0, dt_q[0]};
         OFS_DEADTIME_B: rdata_d = {20'd0, dt_q[1]};
         OFS_DEADTIME_C: rdata_d = {20'd0, dt_q[2]};
         OFS_DT_BUS_C:   rdata_d = {13'd0, dt_bus_c};
         default:        hit     = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         if (rd_en) begin
            prdata <= rdata_d;
         end
      end
   end
endmodule : motor_pwm_period_generator

// file: sim/pwm_gen_properties.sv
// Checker: APB handshake timing and top/bottom pairing of the outputs.
// Sees only the top module's ports; attached by the bind below.
`timescale 1ns/1ps
module pwm_gen_properties
   import pwm_gen_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [5:0]  pwm_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   chk_ready_setup: assert property (setup_s |=> pready)
      else $error("pready missing after setup");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside an access");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_err_unmapped: assert property (setup_s ##0 paddr == 8'hFC |=> pslverr)
      else $error("no error on unmapped address");
   chk_ok_mapped: assert property (setup_s ##0 paddr == OFS_CONTROL |=> !pslverr)
      else $error("error on mapped address");
   // Odd bits settle one edge after reset release, hence the past guard
   chk_pair_a: assert property ($past(presetn) |-> pwm_out[1] != pwm_out[0])
      else $error("pair A not complementary");
   chk_pair_b: assert property ($past(presetn) |-> pwm_out[3] != pwm_out[2])
      else $error("pair B not complementary");
   chk_pair_c: assert property ($past(presetn) |-> pwm_out[5] != pwm_out[4])
      else $error("pair C not complementary");
endmodule : pwm_gen_properties
bind motor_pwm_period_generator pwm_gen_properties u_pwm_gen_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pwm_out(pwm_out));

// file: sim/gate_drive_model.sv
// Gate driver model: counts on-time and turn-ons of the top gate of pair A.
// Assumes start is a one-cycle pulse from the bench, synchronous to pclk.
`timescale 1ns/1ps
module gate_drive_model (
   input  wire logic pclk,
   input  wire logic gate,
   input  wire logic start,
   output logic [7:0] hi_q,
   output logic [7:0] rise_q,
   output logic       busy
);
   logic [7:0] left_q = 8'h00;
   logic       last_q = 1'b0;
   assign busy = left_q != 8'h00;
   // A 128-cycle window holds whole periods of every setting tried
   always_ff @(posedge pclk) begin
      last_q <= gate;
      if (start) begin
         left_q <= 8'h80;
         hi_q   <= 8'h00;
         rise_q <= 8'h00;
      end else if (busy) begin
         left_q <= left_q - 8'h01;
         hi_q   <= hi_q + {7'h00, gate};
         rise_q <= rise_q + {7'h00, gate & ~last_q};
      end
   end
endmodule : gate_drive_model

// file: sim/tb.sv
// Bench: APB register tests, then pair A timing rows at modulus 8.
// Assumes the checker is bound in and the gate model watches output 0.
`timescale 1ns/1ps
module tb;
   import pwm_gen_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, start, busy;
   logic [7:0]  paddr, hi, rise;
   logic [31:0] pwdata, prdata, rd, c0;
   logic [5:0]  pwm_out;
   int failures = 0, checks = 0, cyc = 0;
   logic [6:0]  edg = 7'h7D;
   logic [1:0]  pre [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
   logic [15:0] val [7] = '{16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'hFFFD, 16'h9};
   logic [7:0]  hi_x [7] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h00, 8'h80};
   logic [7:0]  rise_x [7] = '{8'h10, 8'h08, 8'h08, 8'h04, 8'h02, 8'h00, 8'h00};
   motor_pwm_period_generator u_motor_pwm_period_generator (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
   gate_drive_model u_gate_drive_model (.pclk(pclk), .gate(pwm_out[0]),
      .start(start), .hi_q(hi), .rise_q(rise), .busy(busy));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 90000) begin
         failures++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   // No wait-state count is assumed; only the bench timeout ends a stall
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(rd, x);
   endtask : rd_chk
   task automatic wait_clear(input logic [31:0] m);
      do begin
         repeat (30) @(posedge pclk);
         apb(1'b0, OFS_CONTROL, 32'h0);
      end while ((rd & m) != 32'h0);
      check(rd & m, 32'h0);
   endtask : wait_clear
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, start} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(OFS_DEADTIME_C, 32'h0000_0FFF);
      apb(1'b1, OFS_DEADTIME_C, 32'h5);
      rd_chk(OFS_DEADTIME_C, 32'h0000_0FFF);
      apb(1'b0, OFS_COUNT_C, 32'h0);
      c0 = rd;
      apb(1'b0, OFS_COUNT_C, 32'h0);
      check(32'(rd < c0), 32'h1);
      apb(1'b1, OFS_CONTROL, 32'h1);
      apb(1'b1, OFS_MODULUS_C, 32'h10);
      rd_chk(OFS_MODULUS_C, 32'h10);
      apb(1'b1, OFS_DEADTIME_C, 32'h5);
      rd_chk(OFS_DT_BUS_C, 32'h5);
      apb(1'b1, OFS_CONTROL, 32'h3);
      apb(1'b1, OFS_DEADTIME_C, 32'h7);
      rd_chk(OFS_DEADTIME_C, 32'h5);
      apb(1'b0, 8'hFC, 32'h0);
      apb(1'b1, OFS_MODULUS_A, 32'h8);
      apb(1'b1, OFS_PRESCALE, 32'h10);
      apb(1'b1, OFS_CONTROL, 32'h0000_0551);
      wait_clear(32'h0000_0050);
      rd_chk(OFS_DT_BUS_C, 32'h9);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, OFS_PRESCALE, {26'h0, 2'h1, 2'h0, pre[i]});
         apb(1'b1, OFS_VALUE_A, {16'h0, val[i]});
         apb(1'b1, OFS_CONTROL, {21'h0, 2'h2, edg[i], 8'h11});
         wait_clear(32'h0000_0010);
         repeat (80) @(posedge pclk);
         start <= 1'b1;
         @(posedge pclk);
         start <= 1'b0;
         do @(negedge pclk); while (busy !== 1'b0);
         check(32'(hi), 32'(hi_x[i]));
         check(32'(rise), 32'(rise_x[i]));
         @(posedge pclk);
      end
      close_out();
   end
endmodule : tb
